/* File: core/oqs_pkg.sv */
`default_nettype none
package oqs_pkg;
	typedef enum logic [3:0] {
		OQS_CMD_NONE, OQS_CMD_INIT, OQS_CMD_INIT_CONT_ON, OQS_CMD_INIT_CONT_OFF,
		OQS_CMD_TRG, OQS_CMD_OPC, OQS_CMD_OPC_Q, OQS_CMD_CLS, OQS_CMD_RST,
		OQS_CMD_SAV, OQS_CMD_RCL, OQS_CMD_OPT_Q, OQS_CMD_SRE, OQS_CMD_SRE_Q,
		OQS_CMD_STB_Q
	} oqs_cmd_e;
	localparam logic [7:0] OQS_ASCII_ONE   = 8'h31;
	localparam logic [7:0] OQS_ASCII_ZERO  = 8'h30;
	localparam logic [7:0] OQS_SLOT_ID     = 8'h00;
	localparam logic [7:0] OQS_SRE_RESET   = 8'h00;
	localparam logic [7:0] OQS_SRE_MASK    = 8'hbd;
	localparam int         OQS_MSS_BIT     = 6;
	localparam int         OQS_MAV_BIT     = 4;
	localparam int         OQS_SETUP_W     = 16;
	// arbitrary neutral preset and option name code
	localparam logic [15:0] OQS_PRESET     = 16'h0000;
	localparam logic [7:0]  OQS_OPT_NAME   = 8'h53;
endpackage
`default_nettype wire

/* File: core/oqs_top.sv */
`timescale 1ns/10ps
`default_nettype none
module oqs_top
	import oqs_pkg::*;
(
	input  wire logic        core_clk_in,
	input  wire logic        rst_in,
	input  wire logic        cmd_valid_in,
	input  wire logic [3:0]  cmd_code_in,
	input  wire logic [7:0]  cmd_param_in,
	input  wire logic        dev_clear_in,
	input  wire logic        trig_idle_in,
	input  wire logic        trg_action_done_in,
	input  wire logic        trg_src_wait_in,
	input  wire logic        talk_addr_in,
	input  wire logic        scanner_in,
	input  wire logic        recall_fail_in,
	input  wire logic [15:0] live_setup_in,
	input  wire logic [7:0]  status_in,
	output logic             cmd_ready_out,
	output logic             tx_valid_out,
	output logic [7:0]       tx_data_out,
	output logic             mav_out,
	output logic             opc_event_out,
	output logic [7:0]       sre_out,
	output logic [7:0]       stb_out,
	output logic             srq_out,
	output logic             cont_init_out,
	output logic             recall_valid_out,
	output logic [15:0]      recall_setup_out
);
	typedef enum logic [1:0] {OQS_IDLE, OQS_ACTIVE} oqs_q_e;

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [4:0] sync1_ff;
	logic [4:0] sync2_ff;
	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end
		else
		begin
			sync1_ff <= {trig_idle_in, trg_action_done_in, trg_src_wait_in, talk_addr_in,
				dev_clear_in};
			sync2_ff <= sync1_ff;
		end
	end
	wire s_idle  = sync2_ff[4];
	wire s_done  = sync2_ff[3];
	wire s_wait  = sync2_ff[2];
	wire s_talk  = sync2_ff[1];
	wire s_dcl   = sync2_ff[0];

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	oqs_q_e     q_ff, nxt_q;
	logic       oc_ff;
	logic       trg_busy_ff;
	logic       cont_ff;
	logic       mav_ff;
	logic [7:0] qbyte_ff;
	logic [7:0] sre_ff;
	logic [15:0] slot_ff;
	logic       ready_ff;
	logic       txv_ff;
	logic [7:0] txd_ff;
	logic       opc_ev_ff;
	logic       srq_ff;
	logic [7:0] stb_ff;
	logic       rv_ff;
	logic [15:0] rs_ff;

	wire take     = cmd_valid_in && ready_ff;
	// code gated by the handshake, so the decode stays a pure function of its inputs
	wire [3:0] taken_code = take ? cmd_code_in : OQS_CMD_NONE;
	function automatic logic is_cmd(input logic [3:0] c, input oqs_cmd_e k);
		is_cmd = (c == k);
	endfunction
	wire c_cont_on  = is_cmd(taken_code, OQS_CMD_INIT_CONT_ON);
	wire c_cont_off = is_cmd(taken_code, OQS_CMD_INIT_CONT_OFF);
	wire c_init   = is_cmd(taken_code, OQS_CMD_INIT) || c_cont_on;
	wire c_trg    = is_cmd(taken_code, OQS_CMD_TRG);
	wire c_rst    = is_cmd(taken_code, OQS_CMD_RST);
	wire c_clr    = c_rst || is_cmd(taken_code, OQS_CMD_CLS);
	wire c_opcq   = is_cmd(taken_code, OQS_CMD_OPC_Q);
	wire c_opc    = is_cmd(taken_code, OQS_CMD_OPC);
	wire slot_ok  = cmd_param_in == OQS_SLOT_ID;
	wire c_sav    = is_cmd(taken_code, OQS_CMD_SAV) && slot_ok;
	wire c_rcl    = is_cmd(taken_code, OQS_CMD_RCL) && slot_ok;
	wire c_optq   = is_cmd(taken_code, OQS_CMD_OPT_Q);
	wire c_sre    = is_cmd(taken_code, OQS_CMD_SRE);
	wire c_sreq   = is_cmd(taken_code, OQS_CMD_SRE_Q);
	wire c_stbq   = is_cmd(taken_code, OQS_CMD_STB_Q);
	// trigger model idle and no bus trigger running
	wire no_pend  = s_idle && !trg_busy_ff && !c_init && !c_trg;
	// bus trigger ends on action done or halt at a control source
	wire trg_end  = s_done || s_wait;

	// ----------------------------------------
	// completion query tracker
	// ----------------------------------------
	wire q_fire   = (q_ff == OQS_ACTIVE) && no_pend;
	wire imm_fire = c_opcq && no_pend;
	wire tok_load = q_fire || imm_fire;
	always_comb
	begin
		nxt_q = q_ff;
		case (q_ff)
			OQS_IDLE:   if (c_opcq && !no_pend) nxt_q = OQS_ACTIVE;
			OQS_ACTIVE: if (no_pend) nxt_q = OQS_IDLE;
			default:    nxt_q = OQS_IDLE;
		endcase
		if (c_clr || s_dcl)
			nxt_q = OQS_IDLE;
	end
	wire        resp_load = tok_load || c_optq || c_sreq || c_stbq;
	wire [7:0]  opt_byte  = scanner_in ? OQS_OPT_NAME : OQS_ASCII_ZERO;
	wire [7:0]  sre_masked = sre_ff & OQS_SRE_MASK;
	wire [7:0]  stat_mav  = (status_in & ~(8'h01 << OQS_MAV_BIT)) |
		({7'h00, mav_ff} << OQS_MAV_BIT);
	wire        mss       = |(stat_mav & sre_masked & ~(8'h01 << OQS_MSS_BIT));
	wire [7:0]  stb_now   = mss ? (stat_mav | (8'h01 << OQS_MSS_BIT)) :
		(stat_mav & ~(8'h01 << OQS_MSS_BIT));
	wire [7:0]  resp_byte = tok_load ? OQS_ASCII_ONE : c_optq ? opt_byte :
		c_sreq ? sre_masked : stb_now;
	wire        send      = mav_ff && s_talk;
	// opc-command pending flag also cancelled by reset
	wire        oc_fire   = oc_ff && no_pend;
	wire        rise      = |(stb_now & ~stb_ff & sre_masked);

	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			q_ff        <= OQS_IDLE;
			oc_ff       <= 1'b0;
			trg_busy_ff <= 1'b0;
			cont_ff     <= 1'b0;
			mav_ff      <= 1'b0;
			qbyte_ff    <= 8'h00;
			sre_ff      <= OQS_SRE_RESET;
			slot_ff     <= OQS_PRESET;
			ready_ff    <= 1'b1;
			txv_ff      <= 1'b0;
			txd_ff      <= 8'h00;
			opc_ev_ff   <= 1'b0;
			srq_ff      <= 1'b0;
			stb_ff      <= 8'h00;
			rv_ff       <= 1'b0;
			rs_ff       <= OQS_PRESET;
		end
		else
		begin
			q_ff        <= nxt_q;
			trg_busy_ff <= c_rst ? 1'b0 : c_trg ? 1'b1 : trg_end ? 1'b0 : trg_busy_ff;
			cont_ff     <= c_rst ? 1'b0 : c_cont_on ? 1'b1 : c_cont_off ? 1'b0 : cont_ff;
			oc_ff       <= (c_clr || oc_fire) ? 1'b0 : c_opc ? 1'b1 : oc_ff;
			opc_ev_ff   <= oc_fire && !c_clr;
			// owed tokens dropped on reset
			mav_ff      <= (resp_load && !c_rst) ? 1'b1 : (send || c_rst) ? 1'b0 : mav_ff;
			qbyte_ff    <= resp_load ? resp_byte : qbyte_ff;
			txv_ff      <= send;
			txd_ff      <= send ? qbyte_ff : txd_ff;
			// locked while the query waits; device clear unlocks
			ready_ff    <= !(nxt_q == OQS_ACTIVE) || s_dcl;
			sre_ff      <= c_sre ? (cmd_param_in & OQS_SRE_MASK) : sre_ff;
			slot_ff     <= c_sav ? live_setup_in : (c_rcl && recall_fail_in) ? OQS_PRESET :
				slot_ff;
			rv_ff       <= c_rcl;
			rs_ff       <= c_rcl ? (recall_fail_in ? OQS_PRESET : slot_ff) : rs_ff;
			stb_ff      <= stb_now;
			srq_ff      <= rise ? 1'b1 : mss ? srq_ff : 1'b0;
		end
	end

	assign cmd_ready_out    = ready_ff;
	assign tx_valid_out     = txv_ff;
	assign tx_data_out      = txd_ff;
	assign mav_out          = mav_ff;
	assign opc_event_out    = opc_ev_ff;
	assign sre_out          = sre_ff;
	assign stb_out          = stb_ff;
	assign srq_out          = srq_ff;
	assign cont_init_out    = cont_ff;
	assign recall_valid_out = rv_ff;
	assign recall_setup_out = rs_ff;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	chk_imm_token: assert property (imm_fire && !c_rst |=> mav_ff && qbyte_ff == OQS_ASCII_ONE)
		else $error("immediate token missing");
	chk_wait_idle: assert property (q_ff == OQS_ACTIVE && !no_pend |=> !mav_ff || $past(mav_ff))
		else $error("token before idle");
	chk_active_lock: assert property (q_ff == OQS_ACTIVE && !s_dcl |-> !cmd_ready_out)
		else $error("command taken while locked");
	chk_talk_only: assert property (tx_valid_out |-> $past(s_talk))
		else $error("sent while not talker");
	chk_rst_drop: assert property (c_rst |=> !mav_ff && q_ff == OQS_IDLE)
		else $error("reset kept token");
	chk_sre_mask: assert property ((sre_out & ~OQS_SRE_MASK) == 8'h00)
		else $error("unused enable bit set");
	chk_srq_rise: assert property (rise |=> srq_out)
		else $error("service request missing");
	chk_mss_bit: assert property (stb_out[OQS_MSS_BIT] == $past(mss))
		else $error("summary bit wrong");
	chk_opc_cmd: assert property (opc_event_out |-> $past(oc_ff))
		else $error("event bit without command");
	cov_imm: cover property (imm_fire);
	cov_wait: cover property (q_ff == OQS_ACTIVE ##[1:20] q_ff == OQS_IDLE);
	cov_send: cover property (tx_valid_out);
	cov_srq: cover property (srq_out);
endmodule // oqs_top
`default_nettype wire

/* File: tb/oqs_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module oqs_host_model
(
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       listen_in,
	input  wire logic       tx_valid_in,
	input  wire logic [7:0] tx_data_in,
	output logic            talk_addr_out,
	output logic [7:0]      rx_byte_out,
	output logic [7:0]      rx_count_out
);
	// addressed to talk, one clock late, while the bench raises listen_in
	always_ff @(posedge clk_in) talk_addr_out <= listen_in;
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			rx_count_out <= 8'h00;
		else if (tx_valid_in)
		begin
			rx_byte_out  <= tx_data_in;
			rx_count_out <= rx_count_out + 8'h01;
		end
	end
endmodule // oqs_host_model
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import oqs_pkg::*;
	`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin failures++; \
		$display("wrong value at %0t: got %h want %h", $time, a, e); end end
	logic clk = 0, rst = 1, cv = 0, dclr = 0, tidle = 1, tdone = 0, twait = 0;
	logic scan = 0, rfail = 0, listen = 0, talk, rdy, txv, mav, opce, srq, rv, cont;
	logic [3:0] cc = 0;
	logic [7:0] cp = 0, stat = 0, txd, service_request_enable, stb, rxb, rxn;
	logic [15:0] live = 0, rset;
	int failures = 0, samples_checked = 0, cyc = 0, i;
	oqs_top dut (.core_clk_in(clk), .rst_in(rst), .cmd_valid_in(cv), .cmd_code_in(cc),
		.cmd_param_in(cp), .dev_clear_in(dclr), .trig_idle_in(tidle),
		.trg_action_done_in(tdone), .trg_src_wait_in(twait), .talk_addr_in(talk),
		.scanner_in(scan), .recall_fail_in(rfail), .live_setup_in(live),
		.status_in(stat), .cmd_ready_out(rdy), .tx_valid_out(txv), .tx_data_out(txd),
		.mav_out(mav), .opc_event_out(opce), .sre_out(service_request_enable), .stb_out(stb),
		.srq_out(srq), .cont_init_out(cont), .recall_valid_out(rv), .recall_setup_out(rset));
	oqs_host_model host (.clk_in(clk), .rst_in(rst), .listen_in(listen), .tx_valid_in(txv),
		.tx_data_in(txd), .talk_addr_out(talk), .rx_byte_out(rxb), .rx_count_out(rxn));
	initial forever #4 clk = ~clk;
	// -------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------
	task automatic cyc_n(input int n); repeat (n) @(negedge clk); endtask
	task automatic cmd(input oqs_cmd_e c, input logic [7:0] p);
		@(negedge clk); cv = 1; cc = c; cp = p;
		while (rdy !== 1'b1) @(negedge clk);
		@(negedge clk); cv = 0;
	endtask
	task automatic reply(input logic [7:0] e);
		logic [7:0] n0;
		n0 = rxn; listen = 1;
		for (i = 0; i < 10 && rxn === n0; i++) @(negedge clk);
		listen = 0;
		`CHK(rxn, n0 + 8'h01)
		`CHK(rxb, e)
		`CHK(mav, 1'b0)
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// -------------------------------------------------------------
	// scenarios
	// -------------------------------------------------------------
	task automatic t_idle_query;
		cmd(OQS_CMD_OPC_Q, 8'h00);
		`CHK(mav, 1'b1)
		cyc_n(6);
		`CHK(rxn, 8'h00)
		`CHK(stb[OQS_MAV_BIT], 1'b1)
		reply(OQS_ASCII_ONE);
		$display("test idle query done");
	endtask
	task automatic t_busy_query;
		tidle = 0; cyc_n(3);
		cmd(OQS_CMD_INIT, 8'h00); cmd(OQS_CMD_OPC_Q, 8'h00); cyc_n(6);
		`CHK(rdy, 1'b0)
		`CHK(mav, 1'b0)
		tidle = 1;
		for (i = 0; i < 8 && mav !== 1'b1; i++) @(negedge clk);
		`CHK(mav, 1'b1)
		`CHK(rdy, 1'b1)
		reply(OQS_ASCII_ONE);
		$display("test busy query done");
	endtask
	task automatic t_enable;
		cmd(OQS_CMD_SRE, 8'hff);
		`CHK(service_request_enable, OQS_SRE_MASK)
		cmd(OQS_CMD_SRE_Q, 8'h00); reply(OQS_SRE_MASK);
		stat = 8'h01; cyc_n(4);
		`CHK(srq, 1'b1)
		`CHK(stb[OQS_MSS_BIT], 1'b1)
		cmd(OQS_CMD_STB_Q, 8'h00); reply(8'h41);
		`CHK(stb[OQS_MSS_BIT], 1'b1)
		cmd(OQS_CMD_SRE, 8'h00); cyc_n(4);
		`CHK(srq, 1'b0)
		`CHK(stb[OQS_MSS_BIT], 1'b0)
		stat = 8'h00;
		$display("test enable done");
	endtask
	task automatic t_option;
		cmd(OQS_CMD_OPT_Q, 8'h00); reply(OQS_ASCII_ZERO);
		scan = 1; cmd(OQS_CMD_OPT_Q, 8'h00); reply(OQS_OPT_NAME);
		$display("test option done");
	endtask
	task automatic t_setup;
		live = 16'h1234; cmd(OQS_CMD_SAV, 8'h00); live = 16'hbeef;
		cmd(OQS_CMD_SAV, 8'h01);
		cmd(OQS_CMD_RCL, 8'h00);
		for (i = 0; i < 8 && rv !== 1'b1; i++) @(negedge clk);
		`CHK(rset, 16'h1234)
		rfail = 1; cmd(OQS_CMD_RCL, 8'h00);
		for (i = 0; i < 8 && rv !== 1'b1; i++) @(negedge clk);
		`CHK(rset, OQS_PRESET)
		rfail = 0; cmd(OQS_CMD_RCL, 8'h00);
		for (i = 0; i < 8 && rv !== 1'b1; i++) @(negedge clk);
		`CHK(rset, OQS_PRESET)
		$display("test setup done");
	endtask
	task automatic t_event_reset;
		tidle = 0; cyc_n(3); cmd(OQS_CMD_INIT, 8'h00); cmd(OQS_CMD_OPC, 8'h00);
		tidle = 1;
		for (i = 0; i < 8 && opce !== 1'b1; i++) @(negedge clk);
		`CHK(opce, 1'b1)
		tidle = 0; cyc_n(3); cmd(OQS_CMD_INIT, 8'h00); cmd(OQS_CMD_OPC, 8'h00);
		cmd(OQS_CMD_RST, 8'h00); tidle = 1;
		for (i = 0; i < 8 && opce !== 1'b1; i++) @(negedge clk);
		`CHK(opce, 1'b0)
		tidle = 0; cyc_n(3); cmd(OQS_CMD_INIT, 8'h00); cmd(OQS_CMD_OPC, 8'h00);
		cmd(OQS_CMD_CLS, 8'h00); tidle = 1;
		for (i = 0; i < 8 && opce !== 1'b1; i++) @(negedge clk);
		`CHK(opce, 1'b0)
		$display("test event reset done");
	endtask
	task automatic t_trigger;
		int k;
		for (k = 0; k < 2; k++)
		begin
			cmd(OQS_CMD_TRG, 8'h00); cmd(OQS_CMD_OPC_Q, 8'h00); cyc_n(4);
			`CHK(mav, 1'b0)
			tdone = (k == 0); twait = (k == 1);
			for (i = 0; i < 8 && mav !== 1'b1; i++) @(negedge clk);
			`CHK(mav, 1'b1)
			tdone = 0; twait = 0;
			reply(OQS_ASCII_ONE);
		end
		$display("test bus trigger done");
	endtask
	task automatic t_dev_clear;
		tidle = 0; cyc_n(3);
		cmd(OQS_CMD_INIT_CONT_ON, 8'h00);
		`CHK(cont, 1'b1)
		cmd(OQS_CMD_OPC_Q, 8'h00); cyc_n(6);
		`CHK(rdy, 1'b0)
		dclr = 1;
		for (i = 0; i < 8 && rdy !== 1'b1; i++) @(negedge clk);
		`CHK(rdy, 1'b1)
		`CHK(mav, 1'b0)
		dclr = 0; cyc_n(3);
		cmd(OQS_CMD_INIT_CONT_OFF, 8'h00);
		`CHK(cont, 1'b0)
		tidle = 1; cyc_n(3);
		$display("test device clear done");
	endtask
	task automatic t_reset_token;
		logic [7:0] n0;
		cmd(OQS_CMD_OPC_Q, 8'h00);
		`CHK(mav, 1'b1)
		n0 = rxn;
		cmd(OQS_CMD_RST, 8'h00);
		`CHK(mav, 1'b0)
		listen = 1; cyc_n(8); listen = 0;
		`CHK(rxn, n0)
		$display("test reset token done");
	endtask
	// -------------------------------------------------------------
	// sequence and hang guard
	// -------------------------------------------------------------
	always @(posedge clk) if (++cyc > 3000) begin failures++; end_sim; end
	initial
	begin
		cyc_n(3); rst = 0; cyc_n(3);
		`CHK(rdy, 1'b1)
		`CHK(service_request_enable, OQS_SRE_RESET)
		t_idle_query; t_busy_query; t_trigger; t_enable; t_option; t_setup;
		t_event_reset; t_dev_clear; t_reset_token;
		end_sim;
	end
endmodule // tb_top
`default_nettype wire
